//--- hw/program_memory_protect_and_id.v
// Overview of operation
// - CPU program reads always pass through.
// - Protected: programmer writes refused, reads zero.
// - CPU program writes gated only by self-write setting.
// - Two-bit field sizes the shielded region.
// - Block CPU writes inside region, allow outside.
// - Four user ID words readable and writable.
// - Device and revision words fixed, read-only.
// - Programmer can read both identity words.
// - Code protect clears only by bulk erase.
//
// The AXI4-Lite slave port is this design's own decision.
`include "pmp_defs.vh"

module program_memory_protect_and_id #(
  // Arbitrary values, not any real part
  parameter [13:0] DEVICE_ID = 14'h1234,
  parameter [13:0] REVISION_ID = 14'h0001
) (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire nv_code_protect_n,
  input wire [1:0] nv_self_write_protect_sel,
  input wire nv_debug_disable,
  input wire cpu_req,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire [13:0] cpu_wdata,
  output wire cpu_ready,
  output reg cpu_done,
  output reg cpu_refused,
  output reg [13:0] cpu_rdata,
  input wire prg_req,
  input wire prg_we,
  input wire [15:0] prg_addr,
  input wire [13:0] prg_wdata,
  input wire prg_bulk_erase,
  output wire prg_ready,
  output reg prg_done,
  output reg prg_refused,
  output reg [13:0] prg_rdata,
  output wire [15:0] flash_addr,
  output wire flash_wr_en,
  output wire [13:0] flash_wr_data,
  input wire [13:0] flash_rd_data,
  output reg flash_erase,
  input wire awvalid,
  output wire awready,
  input wire [17:0] awaddr,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [17:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp
);

  reg loaded;
  reg code_protect_n;
  reg [1:0] self_write_protect_sel;
  reg debug_disable;
  reg prg_lock;
  reg cpu_blocked_flag;
  reg prg_refused_flag;
  reg [13:0] user_id [0:3];
  reg aw_held;
  reg w_held;
  reg [15:0] aw_index;
  reg [31:0] w_data;
  reg [1:0] w_strb;
  wire cpu_wr_blocked;

  // CPU has priority; programmer waits for a free cycle
  wire sel_cpu = loaded & cpu_req;
  wire sel_prg = loaded & prg_req & ~cpu_req & ~prg_lock;
  wire [15:0] acc_addr = sel_cpu ? cpu_addr : prg_addr;
  wire acc_we = sel_cpu ? cpu_we : prg_we;
  wire in_cfg = acc_addr[`CFG_SPACE_BIT];
  wire user_hit = (acc_addr >= `USER_ID_FIRST) & (acc_addr <= `USER_ID_LAST);
  wire cfg_ro_write = acc_we & in_cfg & ~user_hit;

  assign cpu_ready = sel_cpu;
  assign prg_ready = sel_prg;

  write_region_check region_check (
    .addr(cpu_addr),
    .sel(self_write_protect_sel),
    .blocked(cpu_wr_blocked)
  );

  wire cpu_prog_wr = sel_cpu & cpu_we & ~in_cfg & ~cpu_wr_blocked;
  wire prg_prog_wr = sel_prg & prg_we & ~in_cfg & code_protect_n;
  assign flash_wr_en = cpu_prog_wr | prg_prog_wr;
  assign flash_addr = acc_addr;
  assign flash_wr_data = sel_cpu ? cpu_wdata : prg_wdata;

  wire cpu_refuse_now = sel_cpu & ((cpu_we & ~in_cfg & cpu_wr_blocked) | cfg_ro_write);
  wire prg_refuse_now = sel_prg & ((prg_we & ~in_cfg & ~code_protect_n) | cfg_ro_write);
  wire port_user_wr = (sel_cpu | sel_prg) & acc_we & user_hit;

  function [13:0] cfg_read;
    input [15:0] a;
    begin
      if ((a >= `USER_ID_FIRST) && (a <= `USER_ID_LAST))
        cfg_read = user_id[a[1:0]];
      else if (a == `DEVICE_ID_ADDR)
        cfg_read = DEVICE_ID;
      else if (a == `REVISION_ID_ADDR)
        cfg_read = REVISION_ID;
      else
        cfg_read = `ZERO_WORD;
    end
  endfunction

  // Settings capture and access answers
  always @(posedge clk) begin
    if (!resetn) begin
      loaded <= 1'b0;
      code_protect_n <= `CP_SAFE;
      self_write_protect_sel <= `WRT_ALL;
      debug_disable <= 1'b1;
      cpu_done <= 1'b0;
      cpu_refused <= 1'b0;
      cpu_rdata <= `ZERO_WORD;
      prg_done <= 1'b0;
      prg_refused <= 1'b0;
      prg_rdata <= `ZERO_WORD;
      flash_erase <= 1'b0;
    end else if (clk_en) begin
      cpu_done <= sel_cpu;
      prg_done <= sel_prg;
      cpu_refused <= cpu_refuse_now;
      prg_refused <= prg_refuse_now;
      flash_erase <= 1'b0;
      if (!loaded) begin
        loaded <= 1'b1;
        code_protect_n <= nv_code_protect_n;
        self_write_protect_sel <= nv_self_write_protect_sel;
        debug_disable <= nv_debug_disable;
      end else if (prg_bulk_erase && !prg_lock) begin
        code_protect_n <= `CP_ERASED;
        self_write_protect_sel <= `WRT_NONE;
        flash_erase <= 1'b1;
      end
      if (sel_cpu)
        cpu_rdata <= in_cfg ? cfg_read(cpu_addr) : flash_rd_data;
      if (sel_prg)
        prg_rdata <= in_cfg ? cfg_read(prg_addr) : (code_protect_n ? flash_rd_data : `ZERO_WORD);
    end
  end

  // Bus write channel acceptance
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  wire axi_wr = aw_held & w_held & ~bvalid;
  wire axi_user_hit = (aw_index >= `USER_ID_FIRST) & (aw_index <= `USER_ID_LAST);
  wire axi_ctl_hit = aw_index == `REG_CONTROL;

  always @(posedge clk) begin : user_id_store
    integer i;
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1)
        user_id[i] <= `ERASED_WORD;
    end else if (clk_en) begin
      if (loaded && prg_bulk_erase && !prg_lock) begin
        for (i = 0; i < 4; i = i + 1)
          user_id[i] <= `ERASED_WORD;
      end else begin
        if (axi_wr && axi_user_hit)
          user_id[aw_index[1:0]] <= {w_strb[1] ? w_data[13:8] : user_id[aw_index[1:0]][13:8],
                                     w_strb[0] ? w_data[7:0] : user_id[aw_index[1:0]][7:0]};
        if (port_user_wr)
          user_id[acc_addr[1:0]] <= flash_wr_data;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_index <= 16'h0000;
      w_data <= 32'h00000000;
      w_strb <= 2'b00;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      prg_lock <= 1'b0;
      cpu_blocked_flag <= 1'b0;
      prg_refused_flag <= 1'b0;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_index <= awaddr[17:2];
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb[1:0];
      end
      if (axi_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (axi_user_hit | axi_ctl_hit) ? `RESP_OKAY : `RESP_SLVERR;
        if (axi_ctl_hit && w_strb[0])
          prg_lock <= w_data[`CTL_PRG_LOCK];
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      // Set wins over clear
      if (axi_wr && axi_ctl_hit && w_strb[0] && w_data[`CTL_CLEAR_FLAGS]) begin
        cpu_blocked_flag <= cpu_refuse_now;
        prg_refused_flag <= prg_refuse_now;
      end else begin
        cpu_blocked_flag <= cpu_blocked_flag | cpu_refuse_now;
        prg_refused_flag <= prg_refused_flag | prg_refuse_now;
      end
    end
  end

  // Bus read channel
  assign arready = ~rvalid;
  wire [15:0] ar_index = araddr[17:2];
  reg [31:0] rd_word;
  reg rd_ok;

  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (ar_index == `REG_STATUS) begin
      rd_word[`ST_CP] = code_protect_n;
      rd_word[`ST_WRT_HI:`ST_WRT_LO] = self_write_protect_sel;
      rd_word[`ST_DEBUG] = debug_disable;
      rd_word[`ST_LOADED] = loaded;
      rd_word[`ST_CPU_BLOCKED] = cpu_blocked_flag;
      rd_word[`ST_PRG_REFUSED] = prg_refused_flag;
    end else if (ar_index == `REG_CONTROL) begin
      rd_word[`CTL_PRG_LOCK] = prg_lock;
    end else if (ar_index[`CFG_SPACE_BIT] && (ar_index <= `REVISION_ID_ADDR)) begin
      // Array read here so user ID writes wake this process
      if ((ar_index >= `USER_ID_FIRST) && (ar_index <= `USER_ID_LAST))
        rd_word[13:0] = user_id[ar_index[1:0]];
      else
        rd_word[13:0] = cfg_read(ar_index);
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- hw/pmp_defs.vh
`ifndef PMP_DEFS_VH
`define PMP_DEFS_VH

// Configuration space word addresses
`define USER_ID_FIRST 16'h8000
`define USER_ID_LAST 16'h8003
`define DEVICE_ID_ADDR 16'h8005
`define REVISION_ID_ADDR 16'h8006
`define CFG_SPACE_BIT 15

// Self-write protect selections and region ends
`define WRT_NONE 2'b11
`define WRT_BOOT 2'b10
`define WRT_HALF 2'b01
`define WRT_ALL 2'b00
`define BOOT_END 16'h01ff
`define HALF_END 16'h0fff
`define ALL_END 16'h1fff

// Erased and safe values
`define ERASED_WORD 14'h3fff
`define CP_ERASED 1'b1
`define CP_SAFE 1'b0
`define ZERO_WORD 14'h0000

// Bus word indices of own registers
`define REG_STATUS 16'h0000
`define REG_CONTROL 16'h0001

// Status fields
`define ST_CP 0
`define ST_WRT_LO 1
`define ST_WRT_HI 2
`define ST_DEBUG 3
`define ST_LOADED 4
`define ST_CPU_BLOCKED 5
`define ST_PRG_REFUSED 6

// Control fields
`define CTL_PRG_LOCK 0
`define CTL_CLEAR_FLAGS 1

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- hw/write_region_check.v
`include "pmp_defs.vh"

module write_region_check (
  input wire [15:0] addr,
  input wire [1:0] sel,
  output reg blocked
);

  always @* begin
    case (sel)
      `WRT_NONE: blocked = 1'b0;
      `WRT_BOOT: blocked = (addr <= `BOOT_END);
      `WRT_HALF: blocked = (addr <= `HALF_END);
      `WRT_ALL: blocked = (addr <= `ALL_END);
      default: blocked = 1'b1;
    endcase
  end

endmodule

//--- tb/flash_model.sv
module flash_model (
  input wire clk,
  input wire [15:0] flash_addr,
  input wire flash_wr_en,
  input wire [13:0] flash_wr_data,
  output wire [13:0] flash_rd_data,
  input wire flash_erase
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] mem [0:8191];
  assign flash_rd_data = mem[flash_addr[12:0]];
  // Blank words read as all ones
  initial begin
    foreach (mem[i]) mem[i] = 14'h3fff;
  end
  always @(posedge clk) begin
    if (flash_erase) begin
      foreach (mem[i]) mem[i] <= 14'h3fff;
    end else if (flash_wr_en) begin
      mem[flash_addr[12:0]] <= flash_wr_data;
    end
  end
endmodule

//--- tb/program_memory_protect_and_id_sva.sv
module pmp_checker (
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire nv_code_protect_n,
  input wire [1:0] nv_self_write_protect_sel,
  input wire cpu_req,
  input wire cpu_we,
  input wire [15:0] cpu_addr,
  input wire cpu_ready,
  input wire cpu_done,
  input wire cpu_refused,
  input wire prg_we,
  input wire [15:0] prg_addr,
  input wire prg_ready,
  input wire prg_done,
  input wire prg_refused,
  input wire [13:0] prg_rdata,
  input wire [15:0] flash_addr,
  input wire flash_wr_en,
  input wire flash_erase
);
  logic ld;
  logic cp;
  logic [1:0] wr;
  wire cpe = cp | flash_erase;
  wire [1:0] wre = flash_erase ? 2'b11 : wr;
  wire [15:0] a = cpu_addr;
  wire blk = !a[15] && ((wre == 2'b10 && a < 16'h0200) || (wre == 2'b01 && a < 16'h1000) ||
    (wre == 2'b00 && a < 16'h2000));
  // Mirror of the settings held by the block
  always @(posedge clk) begin
    if (!resetn) begin
      ld <= 1'b0;
      cp <= 1'b0;
      wr <= 2'b00;
    end else if (clk_en && !ld) begin
      ld <= 1'b1;
      cp <= nv_code_protect_n;
      wr <= nv_self_write_protect_sel;
    end else if (clk_en && flash_erase) begin
      cp <= 1'b1;
      wr <= 2'b11;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ready_gate_a: assert property (cpu_ready == (cpu_req && ld))
    else $error("cpu ready gate");
  cpu_take_a: assert property (cpu_ready && clk_en |=> cpu_done)
    else $error("cpu access lost");
  cpu_first_a: assert property (cpu_req |-> !prg_ready)
    else $error("programmer beat cpu");
  cpu_read_a: assert property (cpu_ready && !cpu_we |-> flash_addr == a && !flash_wr_en)
    else $error("cpu read address");
  self_block_a: assert property (cpu_ready && clk_en && cpu_we && blk |-> !flash_wr_en ##1 cpu_refused)
    else $error("protected self write");
  self_free_a: assert property (cpu_ready && cpu_we && !blk && a < 16'h2000 |-> flash_wr_en)
    else $error("free self write lost");
  prg_write_a: assert property (prg_ready && clk_en && prg_we && !prg_addr[15] && !cpe
    |-> !flash_wr_en ##1 prg_done && prg_refused)
    else $error("protected prg write");
  prg_read_a: assert property (prg_ready && clk_en && !prg_we && !prg_addr[15] && !cpe
    |=> prg_done && prg_rdata == 14'h0000 && !prg_refused)
    else $error("protected prg read");
endmodule

bind program_memory_protect_and_id pmp_checker i_pmp_checker (.*);

//--- tb/test_program_memory_protect_and_id.sv
module test_program_memory_protect_and_id;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] dev_id = 14'h2a5c; // Arbitrary value
  localparam logic [13:0] rev_id = 14'h0042; // Arbitrary value
  logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, nv_code_protect_n = 1'b0;
  logic nv_debug_disable = 1'b1;
  logic [1:0] nv_self_write_protect_sel = 2'b10;
  logic cpu_req = '0, cpu_we = '0, prg_req = '0, prg_we = '0, prg_bulk_erase = '0;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [15:0] cpu_addr = '0, prg_addr = '0;
  logic [13:0] cpu_wdata = '0, prg_wdata = '0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h3;
  wire cpu_ready, cpu_done, cpu_refused, prg_ready, prg_done, prg_refused, flash_wr_en, flash_erase;
  wire awready, wready, bvalid, arready, rvalid;
  wire [13:0] cpu_rdata, prg_rdata, flash_wr_data, flash_rd_data;
  wire [15:0] flash_addr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int error_cnt = 0, checked = 0;
  always #50 clk = ~clk;
  program_memory_protect_and_id #(.DEVICE_ID(dev_id), .REVISION_ID(rev_id)) i_program_memory_protect_and_id (.*);
  flash_model i_flash_model (.*);
  task give_verdict;
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic p, input logic we, input logic [15:0] a, input logic [13:0] d, input logic [13:0] ed,
    input logic er);
    int n;
    logic [15:0] v;
    @(posedge clk);
    {cpu_we, prg_we, cpu_addr, prg_addr, cpu_wdata, prg_wdata} <= {we, we, a, a, d, d};
    cpu_req <= !p;
    prg_req <= p;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (p ? prg_ready : cpu_ready) break;
    end
    if (n == 20) error_cnt++;
    if (n == 20) give_verdict;
    @(posedge clk);
    cpu_req <= 1'b0;
    prg_req <= 1'b0;
    @(negedge clk);
    v = p ? {prg_done, prg_refused, prg_rdata} : {cpu_done, cpu_refused, cpu_rdata};
    // Write data is not echoed
    if (we) v[13:0] = ed;
    chk(v, {1'b1, er, ed});
  endtask
  task axi(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [33:0] e);
    logic ta, tw, tr, f;
    logic [33:0] v;
    @(posedge clk);
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    {awaddr, araddr, wdata} <= {a, a, d};
    f = 1'b0;
    for (int n = 0; n < 20 && !f; n++) begin
      @(negedge clk);
      {ta, tw, tr} = {awready, wready, arready};
      f = w ? bvalid : rvalid;
      v = w ? {bresp, 32'h0} : {rresp, rdata};
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (f) {bready, rready} <= 2'b00;
    end
    if (!f) error_cnt++;
    if (!f) give_verdict;
    chk(v, e);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    axi(0, 18'h00000, 0, {2'b00, 32'h1c});
    acc(0, 1, 16'h0100, 14'h0aaa, 0, 1);
    acc(0, 1, 16'h0300, 14'h0555, 0, 0);
    acc(0, 0, 16'h0300, 0, 14'h0555, 0);
    acc(1, 0, 16'h0300, 0, 14'h0000, 0);
    acc(1, 1, 16'h0400, 14'h0123, 0, 1);
    acc(0, 1, 16'h8002, 14'h1abc, 0, 0);
    acc(1, 0, 16'h8002, 0, 14'h1abc, 0);
    acc(1, 0, 16'h8005, 0, dev_id, 0);
    acc(1, 0, 16'h8006, 0, rev_id, 0);
    acc(0, 1, 16'h8005, 14'h0000, 0, 1);
    axi(1, 18'h20014, 1, {2'b10, 32'h0});
    axi(0, 18'h00008, 0, {2'b10, 32'h0});
    axi(1, 18'h20004, 32'h777, {2'b00, 32'h0});
    acc(0, 0, 16'h8001, 0, 14'h0777, 0);
    @(posedge clk);
    prg_bulk_erase <= 1'b1;
    @(posedge clk);
    prg_bulk_erase <= 1'b0;
    axi(0, 18'h00000, 0, {2'b00, 32'h7f});
    acc(1, 1, 16'h0400, 14'h0123, 0, 0);
    acc(1, 0, 16'h0400, 0, 14'h0123, 0);
    acc(1, 0, 16'h8002, 0, 14'h3fff, 0);
    acc(0, 1, 16'h0100, 14'h0aaa, 0, 0);
    axi(1, 18'h00004, 32'h3, {2'b00, 32'h0});
    axi(0, 18'h00004, 0, {2'b00, 32'h1});
    axi(0, 18'h00000, 0, {2'b00, 32'h1f});
    axi(1, 18'h2000c, 32'h1234, {2'b00, 32'h0});
    axi(0, 18'h2000c, 0, {2'b00, 32'h1234});
    // Second reset with the half-size region selected
    @(posedge clk);
    resetn <= 1'b0;
    nv_self_write_protect_sel <= 2'b01;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    axi(0, 18'h00000, 0, {2'b00, 32'h1a});
    acc(0, 1, 16'h0800, 14'h0abc, 0, 1);
    acc(0, 1, 16'h1800, 14'h0abc, 0, 0);
    acc(0, 0, 16'h1800, 0, 14'h0abc, 0);
    axi(1, 18'h00004, 32'h1, {2'b00, 32'h0});
    @(posedge clk);
    prg_bulk_erase <= 1'b1;
    @(posedge clk);
    prg_bulk_erase <= 1'b0;
    axi(0, 18'h00000, 0, {2'b00, 32'h3a});
    give_verdict;
  end
endmodule
